//--- hdl/csms_pkg.sv
package csms_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_VOL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    localparam int CTRL_POWER_DOWN = 0;
    localparam int CTRL_MUTE = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [7:0] VOL_RST = 8'h00;

    localparam int STAT_STATE = 0;
    localparam int STAT_HW = 4;
    localparam int STAT_RVALID = 5;
    localparam int STAT_RATIO = 16;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int RAMP_FRAMES = 2000;
    localparam int DRAIN_US = 10;
    localparam int DRAIN_CYC = DRAIN_US * CLK_MHZ;
    localparam int RATIO_W = 12;
    localparam logic [RATIO_W-1:0] RATIO_MIN = 12'h040;
    localparam logic [RATIO_W-1:0] RATIO_128 = 12'h080;
    localparam logic [RATIO_W-1:0] RATIO_256 = 12'h100;
    localparam logic [RATIO_W-1:0] RATIO_512 = 12'h200;

    // ---------------------------------------------------------------
    // Routing codes
    // ---------------------------------------------------------------
    localparam logic [2:0] SRC_INPUT_ONE = 3'h0;
    localparam logic [2:0] SRC_DAC1 = 3'h5;
    localparam logic [2:0] SRC_DAC2 = 3'h6;
    localparam logic [1:0] MIX_OFF = 2'h0;

    // Layout equals the CFG register, bit 0 at role
    typedef struct packed {
        logic [1:0] mixer;
        logic deemph;
        logic [2:0] aout3_src;
        logic [2:0] aout2_src;
        logic [2:0] aout1_src;
        logic [2:0] adc_src;
        logic hpf_freeze;
        logic hpf_en;
        logic sp_fault_en;
        logic invert;
        logic zero_cross;
        logic soft_ramp;
        logic freeze;
        logic async_mode;
        logic fmt;
        logic mclk_div;
        logic [1:0] role;
    } csms_cfg_s;

    localparam int CFG_W = $bits(csms_cfg_s);

    localparam csms_cfg_s CFG_RST = '{
        mixer: MIX_OFF, deemph: 1'b0, aout3_src: SRC_INPUT_ONE,
        aout2_src: SRC_DAC2, aout1_src: SRC_DAC1, adc_src: SRC_INPUT_ONE,
        hpf_freeze: 1'b0, hpf_en: 1'b1, sp_fault_en: 1'b1,
        invert: 1'b0, zero_cross: 1'b0, soft_ramp: 1'b1, freeze: 1'b0,
        async_mode: 1'b0, fmt: 1'b0, mclk_div: 1'b0, role: 2'h0};

    typedef enum logic [2:0] {
        ST_STRAP, ST_STANDBY, ST_RAMP, ST_DETECT, ST_RUN, ST_DRAIN
    } csms_state_e;

endpackage : csms_pkg

//--- hdl/csms_ratio_det.sv
`timescale 1ns/100ps
module csms_ratio_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_clock,
    input wire logic bit_clock,
    output logic frame_tick,
    output logic [csms_pkg::RATIO_W-1:0] ratio_q,
    output logic valid_q
);
    logic fr_q;
    logic bc_q;
    logic bc_seen_q;
    logic [csms_pkg::RATIO_W-1:0] cnt_q;
    logic sat;
    logic stable;

    assign frame_tick = frame_clock & ~fr_q;
    assign sat = &cnt_q;
    assign stable = (cnt_q + 1'b1 == ratio_q) && bc_seen_q &&
                    (cnt_q >= csms_pkg::RATIO_MIN);

    // ---------------------------------------------------------------
    // Master clocks counted over one frame period
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_q <= 1'b0;
            bc_q <= 1'b0;
            bc_seen_q <= 1'b0;
            cnt_q <= '0;
            ratio_q <= '0;
            valid_q <= 1'b0;
        end else begin
            fr_q <= frame_clock;
            bc_q <= bit_clock;
            if (frame_tick) begin
                cnt_q <= '0;
                ratio_q <= cnt_q + 1'b1;
                valid_q <= stable;
                bc_seen_q <= 1'b0;
            end else begin
                if (!sat) cnt_q <= cnt_q + 1'b1;
                // A stopped frame clock drops validity once the count saturates
                if (sat) valid_q <= 1'b0;
                if (bit_clock & ~bc_q) bc_seen_q <= 1'b1;
            end
        end
    end

endmodule : csms_ratio_det

//--- hdl/csms_apb.sv
`timescale 1ns/100ps
module csms_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_mode,
    input wire logic [31:0] status,
    output logic [1:0] ctrl_q,
    output csms_pkg::csms_cfg_s cfg_q,
    output logic [7:0] vol_q
);
    logic sel_ctrl;
    logic sel_cfg;
    logic sel_vol;
    logic sel_stat;
    logic mapped;
    logic access;
    logic wr;
    logic [31:0] rd_mux;

    assign sel_ctrl = paddr == csms_pkg::ADDR_CTRL;
    assign sel_cfg = paddr == csms_pkg::ADDR_CFG;
    assign sel_vol = paddr == csms_pkg::ADDR_VOL;
    assign sel_stat = paddr == csms_pkg::ADDR_STAT;
    assign mapped = sel_ctrl | sel_cfg | sel_vol | sel_stat;
    assign access = psel & penable;
    assign pready = 1'b1;
    // Pins own the setup in strapped mode, so writes are refused
    assign pslverr = access & (~mapped | (pwrite & (hw_mode | sel_stat)));
    assign wr = access & pwrite & ~pslverr;
    assign rd_mux = sel_ctrl ? {30'h0, ctrl_q} :
                    sel_cfg ? {{(32 - csms_pkg::CFG_W){1'b0}}, cfg_q} :
                    sel_vol ? {24'h0, vol_q} :
                    sel_stat ? status : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= csms_pkg::CTRL_RST;
            cfg_q <= csms_pkg::CFG_RST;
            vol_q <= csms_pkg::VOL_RST;
            prdata <= 32'h0;
        end else begin
            if (wr && sel_ctrl) ctrl_q <= pwdata[1:0];
            if (wr && sel_cfg) cfg_q <= pwdata[csms_pkg::CFG_W-1:0];
            if (wr && sel_vol) vol_q <= pwdata[7:0];
            // Captured in setup so the zero-wait access sees it
            if (psel && !penable) prdata <= rd_mux;
        end
    end

endmodule : csms_apb

//--- hdl/csms_top.sv
// Overview of operation
// (R1) Host holds reset low until master clock and supplies are stable.
// (R2) Host pulls serial audio out high at reset release for pin mode.
// (R3) Operation starts only once frame clock, bit clock and data arrive; code waits on frame and bit clock only.
// (R4) Pin-mode shutdown: host sends muted input data, then asserts reset.
// (R5) Serial out low at release gives software mode, registers accessible.
// (R6) Clearing the power-down bit in software mode starts power-up.
// (R7) Serial audio out and analog outputs muted during reference ramp.
// (R8) Clock ratio measured over one frame period before normal operation.
// (R9) Software mode rests in standby, converters off, until bit cleared.
// (R10) Host loads all registers while the power-down bit is one.
// (R11) Host starts master clocks before clearing the power-down bit.
// (R12) Setting power-down defers power-down until fully muted.
// (R13) Host asserts reset when supplies fall below operating levels.
// (R14) Pin mode: role, speed, clock divide, format and mute from pins.
// (R15) Pin mode: auto power-up, sync only, no freeze, two ratios only; code accepts three (128, 256, 512).
// (R16) Pin mode: serial port fault output always on, open drain.
// (R17) Pin mode volume defaults: soft ramp, no zero cross, 0 dB, mix off.
// (R18) Pin mode: high-pass filter on with continuous DC subtraction.
// (R19) Pin mode routing: input one to converter, outputs fixed.
// (R20) Pin mode: de-emphasis off on both output converters.
// (R21) Serial out sampled at reset release: high pin mode, low software.
// (R22) Audio output starts only after 2000 sample periods.
// (R23) External mute outputs low in init, reset, mute, power-down.
`timescale 1ns/100ps
module csms_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_clock,
    input wire logic bit_clock,
    input wire logic serial_audio_out_i,
    output logic serial_audio_out_o,
    output logic serial_audio_out_oe,
    input wire logic adc_serial_data,
    input wire logic port_role_select_0,
    input wire logic port_role_select_1,
    input wire logic master_clock_divide_pin,
    input wire logic format_select_pin,
    input wire logic mute_pin,
    input wire logic sp_fault,
    output logic serial_port_fault_out_o,
    output logic serial_port_fault_out_oe,
    output logic external_mute_ctrl_n,
    output csms_pkg::csms_cfg_s cfg_o,
    output logic [7:0] volume_o,
    output logic converters_on,
    output logic audio_enable,
    output logic analog_mute
);
    csms_pkg::csms_state_e state_q;
    csms_pkg::csms_state_e state_d;
    logic hw_mode_q;
    logic [10:0] frames_q;
    logic [7:0] drain_q;
    logic [1:0] ctrl;
    csms_pkg::csms_cfg_s cfg_sw;
    csms_pkg::csms_cfg_s cfg_hw;
    logic [7:0] vol_sw;
    logic [31:0] status;
    logic frame_tick;
    logic [csms_pkg::RATIO_W-1:0] ratio;
    logic ratio_valid;
    logic ratio_ok;
    logic power_down;
    logic mute_req;
    logic ramp_done;
    logic drain_done;
    logic dout_q;
    logic mute_n_q;

    // ---------------------------------------------------------------
    // Register slave and clock ratio detector
    // ---------------------------------------------------------------
    csms_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .hw_mode(hw_mode_q),
        .status(status),
        .ctrl_q(ctrl),
        .cfg_q(cfg_sw),
        .vol_q(vol_sw)
    );

    csms_ratio_det u_ratio (
        .pclk(pclk),
        .presetn(presetn),
        .frame_clock(frame_clock),
        .bit_clock(bit_clock),
        .frame_tick(frame_tick),
        .ratio_q(ratio),
        .valid_q(ratio_valid)
    );

    assign status = {4'h0, ratio, 10'h0, ratio_valid, hw_mode_q, 1'b0,
                     state_q};

    // ---------------------------------------------------------------
    // Configuration selection
    // ---------------------------------------------------------------
    // Pin mode takes package defaults, pins override their fields
    always_comb begin
        cfg_hw = csms_pkg::CFG_RST; // R15 R16 R17 R18 R19 R20
        cfg_hw.role = {port_role_select_1, port_role_select_0}; // R14
        cfg_hw.mclk_div = master_clock_divide_pin; // R14
        cfg_hw.fmt = format_select_pin; // R14
    end

    // Software power-down bit has no meaning in pin mode
    assign power_down = hw_mode_q ? 1'b0 : ctrl[csms_pkg::CTRL_POWER_DOWN];
    assign mute_req = hw_mode_q ? mute_pin : ctrl[csms_pkg::CTRL_MUTE]; // R14

    // Pin mode only locks onto the three supported ratios: 128, 256 and 512
    assign ratio_ok = ratio_valid & (!hw_mode_q ||
                      ratio == csms_pkg::RATIO_128 ||
                      ratio == csms_pkg::RATIO_256 ||
                      ratio == csms_pkg::RATIO_512); // R15

    assign ramp_done = frame_tick &&
                       frames_q == 11'(csms_pkg::RAMP_FRAMES - 1); // R22
    assign drain_done = drain_q == 8'(csms_pkg::DRAIN_CYC - 1);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            csms_pkg::ST_STRAP: begin
                // Strapped mode powers up without waiting on software
                if (serial_audio_out_i) state_d = csms_pkg::ST_RAMP; // R21
                else state_d = csms_pkg::ST_STANDBY; // R5 R21
            end
            csms_pkg::ST_STANDBY: begin
                if (!power_down) state_d = csms_pkg::ST_RAMP; // R6 R9
            end
            csms_pkg::ST_RAMP: begin
                if (power_down) state_d = csms_pkg::ST_DRAIN;
                else if (ramp_done) state_d = csms_pkg::ST_DETECT; // R22
            end
            csms_pkg::ST_DETECT: begin
                if (power_down) state_d = csms_pkg::ST_DRAIN;
                else if (ratio_ok) state_d = csms_pkg::ST_RUN; // R3 R8
            end
            csms_pkg::ST_RUN: begin
                if (power_down) state_d = csms_pkg::ST_DRAIN; // R12
                else if (!ratio_ok) state_d = csms_pkg::ST_DETECT; // R8
            end
            csms_pkg::ST_DRAIN: begin
                // Converters stay powered until the soft mute settles
                if (drain_done) state_d = csms_pkg::ST_STANDBY; // R12
            end
            default: state_d = csms_pkg::ST_STRAP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_q <= csms_pkg::ST_STRAP;
        else state_q <= state_d;
    end

    // Strap caught at the first edge after release, never in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hw_mode_q <= 1'b0;
        else if (state_q == csms_pkg::ST_STRAP)
            hw_mode_q <= serial_audio_out_i; // R21
    end

    // Sample periods counted only while the frame clock runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) frames_q <= '0;
        else if (state_q != csms_pkg::ST_RAMP) frames_q <= '0;
        else if (frame_tick) frames_q <= frames_q + 1'b1; // R22
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) drain_q <= '0;
        else if (state_q != csms_pkg::ST_DRAIN) drain_q <= '0;
        else drain_q <= drain_q + 1'b1; // R12
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_o <= csms_pkg::CFG_RST;
            volume_o <= csms_pkg::VOL_RST;
            dout_q <= 1'b0;
            mute_n_q <= 1'b0;
        end else begin
            cfg_o <= hw_mode_q ? cfg_hw : cfg_sw; // R14
            volume_o <= hw_mode_q ? csms_pkg::VOL_RST : vol_sw; // R17
            // Serial output held low outside normal operation
            dout_q <= adc_serial_data &&
                      state_d == csms_pkg::ST_RUN; // R7
            mute_n_q <= state_d == csms_pkg::ST_RUN && !mute_req &&
                        !power_down; // R23
        end
    end

    // Released during reset and the strap cycle so the pull-up is seen
    assign serial_audio_out_oe = state_q != csms_pkg::ST_STRAP; // R21
    assign serial_audio_out_o = dout_q;
    assign external_mute_ctrl_n = mute_n_q;
    assign converters_on = state_q != csms_pkg::ST_STRAP &&
                           state_q != csms_pkg::ST_STANDBY; // R9
    assign audio_enable = state_q == csms_pkg::ST_RUN; // R3 R8
    assign analog_mute = !audio_enable || mute_req; // R7

    // Open drain: only ever pulls low
    assign serial_port_fault_out_o = 1'b0;
    assign serial_port_fault_out_oe = sp_fault &&
        (hw_mode_q || cfg_sw.sp_fault_en); // R16

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_soft_mode;
        @(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_STRAP && !serial_audio_out_i |=>
            state_q == csms_pkg::ST_STANDBY && !hw_mode_q;
    endproperty
    a_soft_mode: assert property (p_soft_mode) // R5
        else $error("low strap did not give standby");

    property p_hw_mode;
        @(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_STRAP && serial_audio_out_i |=>
            state_q == csms_pkg::ST_RAMP && hw_mode_q;
    endproperty
    a_hw_mode: assert property (p_hw_mode) // R21
        else $error("high strap did not start power-up");

    property p_ramp_mute;
        @(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_RAMP |-> !serial_audio_out_o &&
            analog_mute && !external_mute_ctrl_n;
    endproperty
    a_ramp_mute: assert property (p_ramp_mute) // R7
        else $error("output not muted during ramp");

    property p_ramp_len;
        @(posedge pclk) disable iff (!presetn)
        $past(state_q) == csms_pkg::ST_RAMP &&
            state_q == csms_pkg::ST_DETECT |->
            $past(frames_q) == 11'(csms_pkg::RAMP_FRAMES - 1) &&
            $past(frame_tick);
    endproperty
    a_ramp_len: assert property (p_ramp_len) // R22
        else $error("audio started before 2000 frames");

    property p_run_ratio;
        @(posedge pclk) disable iff (!presetn)
        $rose(audio_enable) |-> $past(ratio_ok) && ratio_valid;
    endproperty
    a_run_ratio: assert property (p_run_ratio) // R8
        else $error("normal operation without a ratio");

    property p_power_down_mute;
        @(posedge pclk) disable iff (!presetn)
        !hw_mode_q && ctrl[csms_pkg::CTRL_POWER_DOWN] |=>
            !external_mute_ctrl_n;
    endproperty
    a_power_down_mute: assert property (p_power_down_mute) // R23
        else $error("mute control released while powered down");

    property p_drain;
        @(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_RUN && power_down |=>
            converters_on [*8] ##[1:300]
            state_q == csms_pkg::ST_STANDBY;
    endproperty
    a_drain: assert property (p_drain) // R12
        else $error("power-down not deferred until muted");

    property p_standby;
        @(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_STANDBY |-> !converters_on &&
            !audio_enable ##1 (state_q == csms_pkg::ST_STANDBY ||
            $past(ctrl[csms_pkg::CTRL_POWER_DOWN]) == 1'b0);
    endproperty
    a_standby: assert property (p_standby) // R9
        else $error("standby left while power-down set");

    property p_hw_cfg;
        @(posedge pclk) disable iff (!presetn)
        hw_mode_q && $past(hw_mode_q) |-> cfg_o.hpf_en &&
            !cfg_o.hpf_freeze && !cfg_o.deemph && !cfg_o.freeze &&
            !cfg_o.async_mode && cfg_o.adc_src == csms_pkg::SRC_INPUT_ONE &&
            volume_o == 8'h00 && cfg_o.role ==
            $past({port_role_select_1, port_role_select_0});
    endproperty
    a_hw_cfg: assert property (p_hw_cfg) // R14 R15 R17 R18 R19 R20
        else $error("pin mode configuration wrong");

    property p_fault;
        @(posedge pclk) disable iff (!presetn)
        hw_mode_q && sp_fault |-> serial_port_fault_out_oe &&
            !serial_port_fault_out_o;
    endproperty
    a_fault: assert property (p_fault) // R16
        else $error("fault output not pulled low");

    c_hw_run: cover property (@(posedge pclk) disable iff (!presetn)
        hw_mode_q && state_q == csms_pkg::ST_RUN);
    c_sw_run: cover property (@(posedge pclk) disable iff (!presetn)
        !hw_mode_q && state_q == csms_pkg::ST_RUN);
    c_drain: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == csms_pkg::ST_DRAIN ##1
        state_q == csms_pkg::ST_STANDBY);

endmodule : csms_top

//--- verif/csms_host_model.sv
`timescale 1ns/100ps
module csms_host_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic strap_hi,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic frame_clock,
    output logic bit_clock,
    output logic sdo_pin
);
    logic [7:0] cnt_q;
    // Released pin settles to the strap resistor level
    assign sdo_pin = sdo_oe ? sdo_o : strap_hi;
    initial begin
        frame_clock = 1'b0;
        bit_clock = 1'b0;
        cnt_q = 8'h00;
    end
    // Port clocks stand still until the host starts them
    always @(posedge pclk) begin
        if (!run) begin
            frame_clock <= 1'b0;
            bit_clock <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            bit_clock <= ~bit_clock;
            cnt_q <= (cnt_q >= half - 8'h01) ? 8'h00 : cnt_q + 8'h01;
            if (cnt_q >= half - 8'h01) begin
                frame_clock <= ~frame_clock;
            end
        end
    end
endmodule : csms_host_model

//--- verif/codec_startup_mode_sequencer_test.sv
`timescale 1ns/100ps
module codec_startup_mode_sequencer_test;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_clock, bit_clock, sdo_pin, sdo_o, sdo_oe;
    logic adc = 1'b1;
    logic rs0 = 1'b1;
    logic rs1 = 1'b0;
    logic clk_div_pin = 1'b1;
    logic fmt = 1'b1;
    logic mute_pin = 1'b0;
    logic sp_fault = 1'b0;
    logic fault_o, fault_oe, mute_n, conv_on, aud_en, amute;
    csms_pkg::csms_cfg_s cfg, exp_cfg;
    logic [7:0] vol;
    logic run = 1'b0;
    logic strap = 1'b0;
    logic [7:0] half = 8'h04;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int compares = 0;

    csms_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_clock(frame_clock),
        .bit_clock(bit_clock), .serial_audio_out_i(sdo_pin),
        .serial_audio_out_o(sdo_o), .serial_audio_out_oe(sdo_oe),
        .adc_serial_data(adc), .port_role_select_0(rs0),
        .port_role_select_1(rs1), .master_clock_divide_pin(clk_div_pin),
        .format_select_pin(fmt), .mute_pin(mute_pin),
        .sp_fault(sp_fault), .serial_port_fault_out_o(fault_o),
        .serial_port_fault_out_oe(fault_oe),
        .external_mute_ctrl_n(mute_n), .cfg_o(cfg), .volume_o(vol),
        .converters_on(conv_on), .audio_enable(aud_en),
        .analog_mute(amute));

    csms_host_model u_host (.pclk(pclk), .run(run), .half(half),
        .strap_hi(strap), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .frame_clock(frame_clock), .bit_clock(bit_clock),
        .sdo_pin(sdo_pin));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [31:0] seen,
             input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, expv, seen);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task do_reset(input logic hw);
        @(posedge pclk);
        presetn <= 1'b0;
        strap <= hw;
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
    endtask : do_reset

    // Short frames cover 1990 of the ramp frames, then 128-clock frames finish the ramp and serve detection
    task bring_up;
        int n;
        @(posedge pclk);
        half <= 8'h04;
        run <= 1'b1;
        repeat (1990) @(posedge frame_clock);
        #1;
        chk("audio_enable in ramp", aud_en, 1'b0);
        chk("mutes in ramp", {amute, mute_n, sdo_o}, 3'b100);
        @(posedge pclk);
        half <= 8'h40;
        n = 0;
        while (aud_en !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        #1;
        chk("audio_enable", aud_en, 1'b1);
        apb(1'b0, csms_pkg::ADDR_STAT, 32'h0);
        chk("ratio", rd[27:16], csms_pkg::RATIO_128);
        chk("state run", rd[2:0], 3'h4);
    endtask : bring_up

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        do_reset(1'b0);
        chk("standby outputs", {conv_on, mute_n}, 2'b00);
        apb(1'b0, csms_pkg::ADDR_STAT, 32'h0);
        chk("sw standby", rd[4:0], 5'h01);
        apb(1'b0, csms_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", rd, {30'h0, csms_pkg::CTRL_RST});
        apb(1'b0, csms_pkg::ADDR_CFG, 32'h0);
        chk("cfg reset", rd, {5'h00, csms_pkg::CFG_RST});
        apb(1'b1, csms_pkg::ADDR_VOL, 32'h0000005a);
        apb(1'b0, csms_pkg::ADDR_VOL, 32'h0);
        chk("vol", {rd[23:0], vol}, 32'h00005a5a);
        apb(1'b1, csms_pkg::ADDR_STAT, 32'h1);
        chk("status write", err, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        apb(1'b1, csms_pkg::ADDR_CTRL, 32'h0);
        @(posedge pclk);
        #1;
        chk("power up", {conv_on, aud_en, amute}, 3'b101);
        bring_up;
        chk("run outputs", {amute, mute_n, sdo_pin}, 3'b011);
        apb(1'b1, csms_pkg::ADDR_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        #1;
        chk("soft mute", {amute, mute_n}, 2'b10);
        apb(1'b1, csms_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, csms_pkg::ADDR_CTRL, 32'h1);
        repeat (150) @(posedge pclk);
        #1;
        chk("drain", {conv_on, mute_n}, 2'b10);
        repeat (60) @(posedge pclk);
        #1;
        chk("powered down", conv_on, 1'b0);
        $display("test software mode done");

        do_reset(1'b1);
        chk("auto power up", conv_on, 1'b1);
        apb(1'b0, csms_pkg::ADDR_STAT, 32'h0);
        chk("pin mode ramp", rd[4:0], 5'h12);
        apb(1'b1, csms_pkg::ADDR_CTRL, 32'h0);
        chk("pdn refused", err, 1'b1);
        exp_cfg = csms_pkg::CFG_RST;
        exp_cfg.role = {rs1, rs0};
        exp_cfg.mclk_div = clk_div_pin;
        exp_cfg.fmt = fmt;
        chk("pin cfg", cfg, exp_cfg);
        chk("pin volume", vol, 8'h00);
        sp_fault <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("fault drive", {fault_oe, fault_o}, 2'b10);
        bring_up;
        mute_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("pin mute", {amute, mute_n}, 2'b10);
        // Pin-mode shutdown: outputs muted first, then reset
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk("reset outputs", {conv_on, aud_en, mute_n, sdo_oe, pready},
            5'h01);
        $display("test pin mode done");
        report_and_stop;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        report_and_stop;
    end
endmodule : codec_startup_mode_sequencer_test
